/* File: rtl/adc_result_regs.sv */
// Result memories, control bytes and interrupt logic behind an APB slave
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module adc_result_regs
  import adc_regs_pkg::*;
(
  input  wire logic                   I_SYS_CLK,
  input  wire logic                   I_RSTN,
  input  wire logic                   I_PSEL,
  input  wire logic                   I_PENABLE,
  input  wire logic                   I_PWRITE,
  input  wire logic [7:0]             I_PADDR,
  input  wire logic [31:0]            I_PWDATA,
  output logic      [31:0]            O_PRDATA,
  output logic                        O_PREADY,
  output logic                        O_PSLVERR,
  input  wire logic                   I_CONV_VALID,
  input  wire logic [3:0]             I_CONV_IDX,
  input  wire logic [RES_W-1:0]       I_CONV_DATA,
  input  wire logic                   I_TOV_EVENT,
  input  wire logic                   I_GIE,
  input  wire logic [3:0]             I_SEQ_IDX,
  output logic                        O_ENC,
  output logic                        O_SEQ_LAST,
  output logic      [MCTL_REF_W-1:0]  O_SEQ_REF,
  output logic      [MCTL_CHAN_W-1:0] O_SEQ_CHAN,
  output logic                        O_IRQ
);
  ////////////////////////////////////////////////////////////////////////
  // Storage
  result_t          mem_reg [NUM_MEM];
  mctl_t            mctl_reg [NUM_MEM];
  logic [15:0]      ie_reg;
  logic [15:0]      ifg_reg;
  logic [15:0]      ifg_next;
  logic             enc_reg;
  logic             tovie_reg;
  logic             ovie_reg;
  logic [3:2]       stat_reg;
  logic [3:2]       stat_next;
  logic [31:0]      prdata_reg;
  mctl_t            seq_reg;
  logic [31:0]      rd_word;

  irq_vec_if vif ();

  irq_vec_enc u_enc (
    .vif (vif.enc)
  );

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  wire        setup_ph = I_PSEL & ~I_PENABLE;
  wire        acc_ph   = I_PSEL & I_PENABLE;
  wire        wr_acc   = acc_ph & I_PWRITE;
  wire [3:0]  idx      = I_PADDR[5:2];
  wire        aligned  = I_PADDR[1:0] == 2'b00;
  wire        is_mem   = aligned & (I_PADDR[7:6] == OFS_MEM[7:6]);
  wire        is_mctl  = aligned & (I_PADDR[7:6] == OFS_MCTL[7:6]);
  wire        is_ie    = hit(I_PADDR, OFS_IE);
  wire        is_ifg   = hit(I_PADDR, OFS_IFG);
  wire        is_iv    = hit(I_PADDR, OFS_IV);
  wire        is_ctrl  = hit(I_PADDR, OFS_CTRL);
  wire        is_stat  = hit(I_PADDR, OFS_STAT);
  wire        is_clr   = hit(I_PADDR, OFS_CLR);
  wire        mapped   = is_mem | is_mctl | is_ie | is_ifg | is_iv |
                         is_ctrl | is_stat | is_clr;
  wire [15:0] idx_dec  = 16'h0001 << idx;
  wire [15:0] conv_dec = I_CONV_VALID ? (16'h0001 << I_CONV_IDX) : 16'h0000;
  // Read or write of a result memory counts as an access
  wire [15:0] mem_touch = (acc_ph & is_mem) ? idx_dec : 16'h0000;
  wire [15:0] mem_wr    = (wr_acc & is_mem) ? idx_dec : 16'h0000;
  // Locked while conversions run so a live sequence never changes
  wire        mctl_wr   = wr_acc & is_mctl & ~enc_reg;

  // Zero-wait slave; data was captured in the setup cycle
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = acc_ph & ~mapped;
  assign O_PRDATA  = prdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // Read multiplexer; write-only clear and unmapped words read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (is_mem) begin
      rd_word = {20'h00000, mem_reg[idx]};
    end else if (is_mctl) begin
      rd_word = {24'h000000, mctl_reg[idx]};
    end else if (is_ie) begin
      rd_word = {16'h0000, ie_reg};
    end else if (is_ifg) begin
      rd_word = {16'h0000, ifg_reg};
    end else if (is_iv) begin
      rd_word = {26'h0000000, vif.code, 1'b0};
    end else if (is_ctrl) begin
      rd_word = {28'h0000000, ovie_reg, tovie_reg, enc_reg, 1'b0};
    end else if (is_stat) begin
      rd_word = {28'h0000000, stat_reg, 2'b00};
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_reg <= rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result memories and control bytes; a core load beats a software write
  for (genvar g = 0; g < NUM_MEM; g++) begin : g_mem
    always_ff @(posedge I_SYS_CLK) begin
      if (!I_RSTN) begin
        mem_reg[g] <= MEM_RST;
      end else if (conv_dec[g]) begin
        mem_reg[g] <= I_CONV_DATA;
      end else if (mem_wr[g]) begin
        mem_reg[g] <= I_PWDATA[RES_W-1:0];
      end
    end

    always_ff @(posedge I_SYS_CLK) begin
      if (!I_RSTN) begin
        mctl_reg[g] <= MCTL_RST;
      end else if (mctl_wr && idx_dec[g]) begin
        mctl_reg[g] <= I_PWDATA[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control and enable registers
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      ie_reg    <= IE_RST;
      enc_reg   <= 1'b0;
      tovie_reg <= 1'b0;
      ovie_reg  <= 1'b0;
    end else if (wr_acc) begin
      if (is_ie) begin
        ie_reg <= I_PWDATA[15:0];
      end
      if (is_ctrl) begin
        enc_reg   <= I_PWDATA[CTL_ENC_BIT];
        tovie_reg <= I_PWDATA[CTL_TOVIE_BIT];
        ovie_reg  <= I_PWDATA[CTL_OVIE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags: a load in the same cycle as a clear or write keeps the flag set
  // A load onto a still-set flag means the old result was never read
  wire [15:0] lost = conv_dec & ifg_reg;

  always_comb begin
    ifg_next = is_ifg & wr_acc ? I_PWDATA[15:0]
                               : ifg_reg & ~mem_touch;
    ifg_next = ifg_next | conv_dec;
    stat_next = stat_reg;
    if (wr_acc && is_clr) begin
      stat_next = stat_reg & ~I_PWDATA[3:2];
    end
    stat_next[CTL_OVIE_BIT]  = stat_next[CTL_OVIE_BIT] | (|lost);
    stat_next[CTL_TOVIE_BIT] = stat_next[CTL_TOVIE_BIT] | I_TOV_EVENT;
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      ifg_reg  <= IFG_RST;
      stat_reg <= 2'b00;
    end else begin
      ifg_reg  <= ifg_next;
      stat_reg <= stat_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt sources and request
  wire ovf_src = stat_reg[CTL_OVIE_BIT] & ovie_reg & I_GIE;
  wire tov_src = stat_reg[CTL_TOVIE_BIT] & tovie_reg & I_GIE;

  assign vif.pend = {ifg_reg & ie_reg, tov_src, ovf_src};
  assign O_IRQ    = |vif.pend;

  ////////////////////////////////////////////////////////////////////////
  // Control byte of the slot the core is working on, one cycle later
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      seq_reg <= MCTL_RST;
    end else begin
      seq_reg <= mctl_reg[I_SEQ_IDX];
    end
  end

  assign O_ENC      = enc_reg;
  assign O_SEQ_LAST = seq_reg[MCTL_LAST_BIT];
  // Codes with bit 6 set take the negative reference, not ground
  assign O_SEQ_REF  = seq_reg[MCTL_REF_LSB +: MCTL_REF_W];
  assign O_SEQ_CHAN = seq_reg[MCTL_CHAN_W-1:0];

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);

  wire [7:0] mctl_idx = mctl_reg[idx];
  wire [7:0] mctl_seq = mctl_reg[I_SEQ_IDX];
  wire       conv_hit = |(conv_dec & idx_dec);

  AST_MEM_TOP_ZERO: assert property (
    (setup_ph && is_mem) |=> (O_PRDATA[31:12] == 20'h00000))
    else $error("Result read shows bits above 11");
  AST_MEM_WRITE: assert property (
    (wr_acc && is_mem && !conv_hit)
      |=> mem_reg[$past(idx)] == $past(I_PWDATA[RES_W-1:0]))
    else $error("Result write not stored");
  AST_MCTL_LOCK: assert property (
    (wr_acc && is_mctl && enc_reg) |=> mctl_reg[$past(idx)] == $past(mctl_idx))
    else $error("Control byte changed while enabled");
  // Start only from edges out of reset; a reset edge loads zero, not the byte
  AST_SEQ_FIELDS: assert property (
    I_RSTN |=> {O_SEQ_LAST, O_SEQ_REF, O_SEQ_CHAN} == $past(mctl_seq))
    else $error("Control fields to core wrong");
  AST_IE_BLOCK: assert property (
    (ie_reg == 16'h0000 && !ovf_src && !tov_src) |-> !O_IRQ)
    else $error("Interrupt without enabled source");
  AST_FLAG_SET: assert property (
    I_CONV_VALID |=> ifg_reg[$past(I_CONV_IDX)])
    else $error("Flag not set by result load");
  AST_FLAG_CLR: assert property (
    (acc_ph && is_mem && !conv_hit) |=> !ifg_reg[$past(idx)])
    else $error("Flag not cleared by memory access");
  AST_VEC_OVF: assert property (
    (setup_ph && is_iv && ovf_src) |=> O_PRDATA == 32'h0000_0002)
    else $error("Overflow not top of vector");
  AST_VEC_NONE: assert property (
    (setup_ph && is_iv && !O_IRQ) |=> O_PRDATA == 32'h0000_0000)
    else $error("Vector not zero when idle");
  AST_OVF_GATE: assert property (
    (|lost && ovie_reg && I_GIE) ##1 (ovie_reg && I_GIE) |-> O_IRQ)
    else $error("Enabled result overflow lost");
  AST_TOV_GATE: assert property (
    (I_TOV_EVENT && tovie_reg && I_GIE) ##1 (tovie_reg && I_GIE) |-> O_IRQ)
    else $error("Enabled time overflow lost");
  AST_IRQ_FLAG: assert property (
    (|(ifg_reg & ie_reg)) |-> O_IRQ && vif.code >= 5'h03 || ovf_src || tov_src)
    else $error("Enabled flag gives no request");

  COV_LOAD: cover property (I_CONV_VALID ##1 O_IRQ);
  COV_LOST: cover property (|lost);
  COV_LOCKED: cover property (wr_acc && is_mctl && enc_reg);
  COV_VEC_LAST: cover property (vif.code == 5'h12);
endmodule
`default_nettype wire

/* File: common/adc_regs_pkg.sv */
// Constants and types of the converter result and interrupt register block
//
// Functional notes
// - Result right-aligned, bits 15-12 read zero
// - Software write overwrites stored conversion result
// - Control byte writable only while conversions disabled
// - Control bit 7 marks last conversion
// - Control bits 6-4 select reference pair
// - Control bits 3-0 select input channel
// - Sixteen enable bits gate result flags
// - Result load sets matching flag
// - Memory access clears flag; software writes flags
// - Vector reports highest pending source, even code
// - Result overflow gated by bit 3, global
// - Time overflow gated by bit 2, global
package adc_regs_pkg;
  localparam int unsigned NUM_MEM = 16;
  localparam int unsigned RES_W   = 12;
  localparam int unsigned NUM_SRC = NUM_MEM + 2;
  localparam int unsigned VEC_W   = 5;

  // Byte offsets; memory and control byte x sit at base + 4x
  localparam logic [7:0] OFS_MEM  = 8'h00;
  localparam logic [7:0] OFS_MCTL = 8'h40;
  localparam logic [7:0] OFS_IE   = 8'h80;
  localparam logic [7:0] OFS_IFG  = 8'h84;
  localparam logic [7:0] OFS_IV   = 8'h88;
  localparam logic [7:0] OFS_CTRL = 8'h8c;
  localparam logic [7:0] OFS_STAT = 8'h90;
  localparam logic [7:0] OFS_CLR  = 8'h94;

  // Main control bits; status and clear share the overflow positions
  localparam int unsigned CTL_ENC_BIT   = 1;
  localparam int unsigned CTL_TOVIE_BIT = 2;
  localparam int unsigned CTL_OVIE_BIT  = 3;

  // Control byte fields
  localparam int unsigned MCTL_LAST_BIT = 7;
  localparam int unsigned MCTL_NEG_BIT  = 6;
  localparam int unsigned MCTL_REF_LSB  = 4;
  localparam int unsigned MCTL_REF_W    = 3;
  localparam int unsigned MCTL_CHAN_W   = 4;

  // Pending vector source positions; memory x sits at SRC_MEM0 + x
  localparam int unsigned SRC_OVF  = 0;
  localparam int unsigned SRC_TOV  = 1;
  localparam int unsigned SRC_MEM0 = 2;

  // Reset values
  localparam logic [7:0]  MCTL_RST = 8'h00;
  localparam logic [11:0] MEM_RST  = 12'h000;
  localparam logic [15:0] IE_RST   = 16'h0000;
  localparam logic [15:0] IFG_RST  = 16'h0000;
  localparam logic [4:0]  VEC_NONE = 5'h00;

  typedef logic [7:0] mctl_t;
  typedef logic [RES_W-1:0] result_t;
endpackage

/* File: common/irq_vec_if.sv */
// Pending sources and encoded vector between register file and encoder
`timescale 1ns/100ps
`default_nettype none
interface irq_vec_if;
  import adc_regs_pkg::*;
  logic [NUM_SRC-1:0] pend;
  logic [VEC_W-1:0]   code;
  modport enc (input pend, output code);
  modport user (output pend, input code);
endinterface
`default_nettype wire

/* File: rtl/irq_vec_enc.sv */
// Priority encoder for the interrupt vector
`timescale 1ns/100ps
`default_nettype none
module irq_vec_enc
  import adc_regs_pkg::*;
(
  irq_vec_if.enc vif
);
  // Lowest set position wins; code is position plus one, zero if none
  function automatic logic [VEC_W-1:0] first_set(
    input logic [NUM_SRC-1:0] p
  );
    logic [VEC_W-1:0] c;
    c = VEC_NONE;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (p[i]) begin
        c = VEC_W'(i + 1);
      end
    end
    return c;
  endfunction

  assign vif.code = first_set(vif.pend);
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the converter result and interrupt registers
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import adc_regs_pkg::*;
  typedef struct {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] exp;
  } row_t;
  logic        clk, rstn, psel, pen, pwr, cvalid, tov, global_irq_enable;
  logic        pready, pslverr, enc, last, irq, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  cidx, sidx, chan;
  logic [2:0]  sref;
  result_t     cdata;
  mctl_t       v;
  int          fails, checks_done;
  row_t        rows [7];

  adc_result_regs i_adc_result_regs (
    .I_SYS_CLK    (clk),
    .I_RSTN       (rstn),
    .I_PSEL       (psel),
    .I_PENABLE    (pen),
    .I_PWRITE     (pwr),
    .I_PADDR      (paddr),
    .I_PWDATA     (pwdata),
    .O_PRDATA     (prdata),
    .O_PREADY     (pready),
    .O_PSLVERR    (pslverr),
    .I_CONV_VALID (cvalid),
    .I_CONV_IDX   (cidx),
    .I_CONV_DATA  (cdata),
    .I_TOV_EVENT  (tov),
    .I_GIE        (global_irq_enable),
    .I_SEQ_IDX    (sidx),
    .O_ENC        (enc),
    .O_SEQ_LAST   (last),
    .O_SEQ_REF    (sref),
    .O_SEQ_CHAN   (chan),
    .O_IRQ        (irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the wait for ready is bounded so a hang ends the run
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // Core load pulse, one cycle wide
  task automatic load(input logic [3:0] i, input result_t d);
    @(posedge clk);
    cvalid <= 1'b1;
    cidx   <= i;
    cdata  <= d;
    @(posedge clk);
    cvalid <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, table of plain accesses, then the awkward cases
  initial begin
    {rstn, psel, pen, pwr, cvalid, tov, global_irq_enable} = 7'h00;
    {paddr, pwdata, cidx, cdata} = '0;
    sidx = 4'h2;
    fails = 0;
    checks_done = 0;
    rows[0] = '{OFS_MCTL, 32'hffffffff, 32'h000000ff};
    rows[1] = '{OFS_MCTL + 8'h3c, 32'h0000005a, 32'h0000005a};
    rows[2] = '{OFS_MEM + 8'h04, 32'hffffffff, 32'h00000fff};
    rows[3] = '{OFS_MEM + 8'h3c, 32'h00001234, 32'h00000234};
    rows[4] = '{OFS_IE, 32'hffffffff, 32'h0000ffff};
    rows[5] = '{OFS_IE, 32'h00000000, 32'h00000000};
    rows[6] = '{OFS_CLR, 32'h0000000c, 32'h00000000};
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    #1 check(32'({enc, last, irq}), 32'h0);
    rd_chk(OFS_MCTL + 8'h3c, 32'h0);
    rd_chk(OFS_IE, 32'h0);
    rd_chk(OFS_IFG, 32'h0);
    rd_chk(OFS_IV, 32'h0);
    for (int r = 0; r < 7; r++) begin
      apb(1'b1, rows[r].addr, rows[r].wdata);
      rd_chk(rows[r].addr, rows[r].exp);
    end
    // Every reference and channel code reaches the core side
    for (int i = 0; i < 16; i++) begin
      v = {i[0], i[2:0], i[3:0]};
      apb(1'b1, OFS_MCTL + 8'h08, 32'(v));
      @(posedge clk);
      #1 check(32'({last, sref, chan}), 32'(v));
    end
    // Vector code of each flag alone, then priority among all
    apb(1'b1, OFS_IE, 32'h0000ffff);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, OFS_IFG, 32'h1 << i);
      rd_chk(OFS_IV, 32'(6 + 2 * i));
    end
    apb(1'b1, OFS_IFG, 32'h0000ffff);
    rd_chk(OFS_IV, 32'h6);
    rd_chk(OFS_MEM, 32'h0);
    rd_chk(OFS_IV, 32'h8);
    apb(1'b1, OFS_IFG, 32'h0);
    #1 check(32'(irq), 32'h0);
    // Core load sets the flag; reading the memory clears it
    load(4'h9, 12'habc);
    #1 check(32'(irq), 32'h1);
    rd_chk(OFS_IFG, 32'h200);
    rd_chk(OFS_MEM + 8'h24, 32'habc);
    rd_chk(OFS_IFG, 32'h0);
    // Overflow sources: own enables on, gated by the global enable
    apb(1'b1, OFS_IE, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h0000000c);
    global_irq_enable <= 1'b1;
    load(4'h4, 12'h111);
    load(4'h4, 12'h222);
    rd_chk(OFS_IV, 32'h2);
    #1 check(32'(irq), 32'h1);
    @(posedge clk);
    tov <= 1'b1;
    @(posedge clk);
    tov <= 1'b0;
    #1 check(32'(irq), 32'h1);
    @(posedge clk);
    global_irq_enable <= 1'b0;
    rd_chk(OFS_IV, 32'h0);
    #1 check(32'(irq), 32'h0);
    rd_chk(OFS_STAT, 32'h0000000c);
    rd_chk(OFS_CTRL, 32'h0000000c);
    // Own enables gate the overflow sources with the global enable on
    global_irq_enable <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h0);
    rd_chk(OFS_IV, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h0000000c);
    apb(1'b1, OFS_CLR, 32'h00000008);
    rd_chk(OFS_IV, 32'h4);
    apb(1'b1, OFS_CLR, 32'h00000004);
    rd_chk(OFS_IV, 32'h0);
    rd_chk(OFS_MEM + 8'h10, 32'h222);
    // Control bytes are frozen while conversions are enabled
    apb(1'b1, OFS_CTRL, 32'h00000002);
    #1 check(32'(enc), 32'h1);
    apb(1'b1, OFS_MCTL + 8'h08, 32'h0);
    rd_chk(OFS_MCTL + 8'h08, 32'hff);
    check(32'(err), 32'h0);
    apb(1'b1, OFS_CTRL, 32'h0);
    // Unmapped and unaligned places answer with an error and zero data
    rd_chk(8'hfc, 32'h0);
    check(32'(err), 32'h1);
    rd_chk(OFS_MCTL + 8'h01, 32'h0);
    check(32'(err), 32'h1);
    // Second reset in mid-run drops a pending request
    apb(1'b1, OFS_IE, 32'h1);
    apb(1'b1, OFS_IFG, 32'h1);
    #1 check(32'(irq), 32'h1);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    #1 check(32'(irq), 32'h0);
    rd_chk(OFS_IFG, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
